// File: ssmc_top.sv
`timescale 1ns/1ps
// How it works
// - Failed download retries on restart while enabled.
// - Auto-address reply overrides server and file.
// - Interrupted flashing reruns update; management blocked.
// - Terminal count holds last good on error.
// - New error bit rewrites diagnostic parameter.
// - Positions numbered one to sixty-three.
// - Each terminal has one of seven types.
// - Digital channels are bits, others words.
// - Analog terminals get equal input/output words.
// - Station error invalidates data, flashes diagnostic.
// - Peripheral fault invalidates only that terminal.
// - Learn mode default on, expert off.
// - Learn setting retained and shown on indicator.
// - Learn mode starts bus, outputs disabled.
// - Learn off stores reference, enables outputs.
// - Compare reference with physical; run if equal.
// - Mismatch lights indicator, blocks data exchange.
// - Learn on plus restart adopts physical.
// - Expert waits for build and start commands.
// - Expert off applies only after restart.
// - Learn mode refuses data access with code.
// - Learn mode holds outputs in reset.
module ssmc_top (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Register port.
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // Restart and update sources.
  input wire logic RESTART_I,
  input wire logic UPD_DONE_I,
  input wire logic UPD_FAIL_I,
  input wire logic FLASH_BUSY_I,
  input wire logic REPLY_VALID_I,
  input wire logic [31:0] REPLY_SERVER_I,
  input wire logic [15:0] REPLY_FILE_I,
  // Local bus scan results.
  input wire logic SCAN_VALID_I,
  input wire logic [ssmc_pkg::SLOT_W-1:0] SCAN_SLOT_I,
  input wire logic [2:0] SCAN_TYPE_I,
  input wire logic [4:0] SCAN_BITS_I,
  input wire logic [3:0] SCAN_WORDS_I,
  input wire logic SCAN_DONE_I,
  input wire logic BUS_ERR_I,
  input wire logic [15:0] DIAG_STAT_I,
  input wire logic [15:0] DIAG_CAUSE_I,
  input wire logic [ssmc_pkg::MAX_SLOTS-1:0] PERIPH_FAULT_I,
  // Indicators and gates.
  output logic START_UPDATE_O,
  output logic MGMT_AVAIL_O,
  output logic [31:0] UPD_SERVER_O,
  output logic [15:0] UPD_FILE_O,
  output logic LEARN_MODE_INDICATOR_O,
  output logic CONFIG_MISMATCH_INDICATOR_O,
  output logic DIAG_FLASH_O,
  output logic OUT_WRITE_EN_O,
  output logic OUTPUTS_RESET_O,
  output logic BUS_RUN_O,
  output logic PD_VALID_O,
  output logic [ssmc_pkg::MAX_SLOTS-1:0] SLOT_VALID_O
);
  import ssmc_pkg::*;

  ssmc_state_t state_ff, nxt_state;
  logic learn_ff, expert_ff, expert_eff_ff, upd_ena_ff, auto_addr_ff;
  logic flash_pend_ff;
  logic [31:0] server_ff;
  logic [15:0] file_ff;
  logic [SLOT_W-1:0] phys_cnt_ff, good_cnt_ff, ref_cnt_ff, slot_sel_ff;
  logic [2:0] phys_type_ff [MAX_SLOTS];
  logic [2:0] ref_type_ff [MAX_SLOTS];
  logic [4:0] chan_ff [MAX_SLOTS];
  logic [3:0] win_ff [MAX_SLOTS];
  logic [3:0] wout_ff [MAX_SLOTS];
  logic [15:0] diag_stat_ff, diag_param_ff, pd_err_ff;
  logic built_ff, stored_ff, learn_was_ff;
  logic [22:0] blink_ff;
  logic match;
  logic scan_ok;
  logic wr_ctrl, wr_cmd;
  logic [31:0] nxt_rdata;

  assign wr_ctrl = WR_I && (ADDR_I == ADR_CTRL);
  assign wr_cmd = WR_I && (ADDR_I == ADR_CMD);
  assign scan_ok = SCAN_VALID_I && (SCAN_SLOT_I != '0);

  // Configuration bits. Learn flag is the retained copy; the host keeps it across power loss.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      learn_ff <= CTRL_LEARN_RST;
      expert_ff <= CTRL_EXPERT_RST;
      upd_ena_ff <= CTRL_UPD_RST;
      auto_addr_ff <= CTRL_AUTO_RST;
    end else if (wr_ctrl) begin
      learn_ff <= WDATA_I[CTRL_LEARN];
      expert_ff <= WDATA_I[CTRL_EXPERT];
      upd_ena_ff <= WDATA_I[CTRL_UPD_ENA];
      auto_addr_ff <= WDATA_I[CTRL_AUTO_ADDR];
    end else if (state_ff == ST_UPDATE && UPD_DONE_I) begin
      upd_ena_ff <= 1'b0;
    end
  end

  // Expert mode may switch on at once; switching off waits for a restart.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      expert_eff_ff <= CTRL_EXPERT_RST;
    end else if (RESTART_I || expert_ff) begin
      expert_eff_ff <= expert_ff;
    end
  end

  // An interrupted flash write leaves this set until an update completes.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      flash_pend_ff <= 1'b0;
    end else if (state_ff == ST_UPDATE && FLASH_BUSY_I && RESTART_I) begin
      flash_pend_ff <= 1'b1;
    end else if (state_ff == ST_UPDATE && UPD_DONE_I) begin
      flash_pend_ff <= 1'b0;
    end
  end

  // Update server and file name.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      server_ff <= 32'h0;
      file_ff <= 16'h0;
    end else if (state_ff == ST_BOOT && REPLY_VALID_I && auto_addr_ff) begin
      server_ff <= REPLY_SERVER_I;
      file_ff <= REPLY_FILE_I;
    end else if (WR_I && ADDR_I == ADR_CMD && WDATA_I[31]) begin
      server_ff <= {16'h0, WDATA_I[15:0]};
    end else if (WR_I && ADDR_I == ADR_CMD && WDATA_I[30]) begin
      file_ff <= WDATA_I[15:0];
    end
  end

  // Physical configuration gathered by the scan.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      phys_cnt_ff <= '0;
      for (int i = 0; i < MAX_SLOTS; i++) begin
        phys_type_ff[i] <= 3'h0;
        chan_ff[i] <= 5'h0;
        win_ff[i] <= 4'h0;
        wout_ff[i] <= 4'h0;
      end
    end else if (RESTART_I) begin
      phys_cnt_ff <= '0;
    end else if (scan_ok) begin
      phys_cnt_ff <= SCAN_SLOT_I;
      phys_type_ff[SCAN_SLOT_I - 6'h1] <= SCAN_TYPE_I;
      if (SCAN_TYPE_I <= TT_DIO) begin
        chan_ff[SCAN_SLOT_I - 6'h1] <= SCAN_BITS_I;
      end else begin
        chan_ff[SCAN_SLOT_I - 6'h1] <= {1'b0, SCAN_WORDS_I};
      end
      win_ff[SCAN_SLOT_I - 6'h1] <= (SCAN_TYPE_I == TT_DOUT) ? 4'h0 : SCAN_WORDS_I;
      if (SCAN_TYPE_I == TT_AIN || SCAN_TYPE_I == TT_AOUT || SCAN_TYPE_I == TT_AIO) begin
        win_ff[SCAN_SLOT_I - 6'h1] <= SCAN_WORDS_I;
        wout_ff[SCAN_SLOT_I - 6'h1] <= SCAN_WORDS_I;
      end else begin
        wout_ff[SCAN_SLOT_I - 6'h1] <= (SCAN_TYPE_I == TT_DIN) ? 4'h0 : SCAN_WORDS_I;
      end
    end
  end

  // Last operable count survives a bus error.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      good_cnt_ff <= '0;
    end else if (!BUS_ERR_I && state_ff == ST_RUN) begin
      good_cnt_ff <= phys_cnt_ff;
    end
  end

  always_comb begin
    match = (ref_cnt_ff == phys_cnt_ff);
    for (int i = 0; i < MAX_SLOTS; i++) begin
      if (i < int'(phys_cnt_ff) && ref_type_ff[i] != phys_type_ff[i]) begin
        match = 1'b0;
      end
    end
  end

  // Reference configuration.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ref_cnt_ff <= '0;
      stored_ff <= 1'b0;
      for (int i = 0; i < MAX_SLOTS; i++) begin
        ref_type_ff[i] <= 3'h0;
      end
    end else if ((learn_was_ff && !learn_ff && state_ff == ST_RUN) ||
                 (state_ff == ST_SCAN && SCAN_DONE_I && learn_ff)) begin
      ref_cnt_ff <= phys_cnt_ff;
      stored_ff <= 1'b1;
      for (int i = 0; i < MAX_SLOTS; i++) begin
        ref_type_ff[i] <= phys_type_ff[i];
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      learn_was_ff <= 1'b1;
    end else begin
      learn_was_ff <= learn_ff;
    end
  end

  // Expert command progress.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      built_ff <= 1'b0;
    end else if (RESTART_I) begin
      built_ff <= 1'b0;
    end else if (wr_cmd && WDATA_I[15:0] == CMD_BUILD_CONFIG && state_ff == ST_EXP_WAIT) begin
      built_ff <= 1'b1;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_BOOT: begin
        if (flash_pend_ff || upd_ena_ff) begin
          nxt_state = ST_UPDATE;
        end else if (expert_eff_ff) begin
          nxt_state = ST_EXP_WAIT;
        end else begin
          nxt_state = ST_SCAN;
        end
      end
      ST_UPDATE: begin
        if (UPD_DONE_I || UPD_FAIL_I) begin
          nxt_state = ST_BOOT;
        end
      end
      ST_SCAN: begin
        if (SCAN_DONE_I) begin
          nxt_state = learn_ff ? ST_RUN : ST_CHECK;
        end
      end
      ST_CHECK: nxt_state = match ? ST_RUN : ST_MISMATCH;
      ST_EXP_WAIT: begin
        if (built_ff) begin
          nxt_state = ST_EXP_CFG;
        end
      end
      ST_EXP_CFG: begin
        if (wr_cmd && WDATA_I[15:0] == CMD_START_XFER) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN, ST_MISMATCH: nxt_state = state_ff;
      default: nxt_state = ST_BOOT;
    endcase
    // A failed download leaves the enable set, so the next restart repeats it.
    if (RESTART_I) begin
      nxt_state = ST_BOOT;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_ff <= ST_BOOT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Diagnostic words; a newly set error bit captures the cause.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      diag_stat_ff <= 16'h0;
      diag_param_ff <= 16'h0;
    end else begin
      diag_stat_ff <= DIAG_STAT_I;
      if ((DIAG_STAT_I & ~diag_stat_ff) != 16'h0) begin
        diag_param_ff <= DIAG_CAUSE_I;
      end
    end
  end

  // Process data access: answer code readable after the request.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pd_err_ff <= ERR_NONE;
    end else if (WR_I && ADDR_I == ADR_PD_REQ) begin
      if (learn_ff && !expert_eff_ff) begin
        pd_err_ff <= ERR_LEARN_ACTIVE;
      end else begin
        pd_err_ff <= ERR_NONE;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      slot_sel_ff <= '0;
    end else if (WR_I && ADDR_I == ADR_SLOT_SEL) begin
      slot_sel_ff <= WDATA_I[SLOT_W-1:0];
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      blink_ff <= '0;
    end else begin
      blink_ff <= blink_ff + 23'h1;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0;
    case (ADDR_I)
      ADR_CTRL: nxt_rdata = {28'h0, auto_addr_ff, upd_ena_ff, expert_ff, learn_ff};
      ADR_STATUS: nxt_rdata = {24'h0, stored_ff, flash_pend_ff, expert_eff_ff, 2'h0, state_ff};
      ADR_COUNT: nxt_rdata = {26'h0, BUS_ERR_I ? good_cnt_ff : phys_cnt_ff};
      ADR_DIAG_STAT: nxt_rdata = {16'h0, diag_stat_ff};
      ADR_DIAG_PARAM: nxt_rdata = {16'h0, diag_param_ff};
      ADR_SLOT_INFO: begin
        if (slot_sel_ff != '0 && slot_sel_ff <= phys_cnt_ff) begin
          nxt_rdata = {13'h0, phys_type_ff[slot_sel_ff - 6'h1], chan_ff[slot_sel_ff - 6'h1],
                       3'h0, win_ff[slot_sel_ff - 6'h1], wout_ff[slot_sel_ff - 6'h1]};
        end else begin
          nxt_rdata = {16'h0, ERR_BAD_SLOT};
        end
      end
      ADR_PD_REQ: nxt_rdata = {16'h0, pd_err_ff};
      default: nxt_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 32'h0;
    end else if (RD_I) begin
      RDATA_O <= nxt_rdata;
    end else begin
      RDATA_O <= 32'h0;
    end
  end

  // Registered outputs.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      START_UPDATE_O <= 1'b0;
      MGMT_AVAIL_O <= 1'b0;
      UPD_SERVER_O <= 32'h0;
      UPD_FILE_O <= 16'h0;
      LEARN_MODE_INDICATOR_O <= 1'b0;
      CONFIG_MISMATCH_INDICATOR_O <= 1'b0;
      DIAG_FLASH_O <= 1'b0;
      OUT_WRITE_EN_O <= 1'b0;
      OUTPUTS_RESET_O <= 1'b1;
      BUS_RUN_O <= 1'b0;
      PD_VALID_O <= 1'b0;
      SLOT_VALID_O <= '0;
    end else begin
      START_UPDATE_O <= (nxt_state == ST_UPDATE);
      MGMT_AVAIL_O <= !flash_pend_ff && (state_ff != ST_UPDATE);
      UPD_SERVER_O <= server_ff;
      UPD_FILE_O <= file_ff;
      LEARN_MODE_INDICATOR_O <= learn_ff && !expert_eff_ff;
      CONFIG_MISMATCH_INDICATOR_O <= (state_ff == ST_MISMATCH) && !expert_eff_ff;
      DIAG_FLASH_O <= (BUS_ERR_I || state_ff == ST_MISMATCH) && blink_ff[22];
      OUT_WRITE_EN_O <= (state_ff == ST_RUN) && (!learn_ff || expert_eff_ff);
      OUTPUTS_RESET_O <= learn_ff && !expert_eff_ff;
      BUS_RUN_O <= (state_ff == ST_RUN);
      PD_VALID_O <= (state_ff == ST_RUN) && !BUS_ERR_I;
      for (int i = 0; i < MAX_SLOTS; i++) begin
        SLOT_VALID_O[i] <= (state_ff == ST_RUN) && !BUS_ERR_I &&
                           (i < int'(phys_cnt_ff)) && !PERIPH_FAULT_I[i];
      end
    end
  end

  a_learn_resets_out: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (learn_ff && !expert_eff_ff) |=> OUTPUTS_RESET_O)
    else $error("Outputs not held in reset during learn mode.");
  a_learn_no_write: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (learn_ff && !expert_eff_ff) |=> !OUT_WRITE_EN_O)
    else $error("Output writing enabled in learn mode.");
  a_pd_refused: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (WR_I && ADDR_I == ADR_PD_REQ && learn_ff && !expert_eff_ff) |=> pd_err_ff == ERR_LEARN_ACTIVE)
    else $error("Process data access not refused in learn mode.");
  a_mismatch_block: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state_ff == ST_CHECK && !match) |=> ##1 (!BUS_RUN_O && !PD_VALID_O))
    else $error("Mismatch did not block data exchange.");
  a_diag_capture: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ((DIAG_STAT_I & ~diag_stat_ff) != 16'h0) |=> diag_param_ff == $past(DIAG_CAUSE_I))
    else $error("Diagnostic parameter not rewritten on new error.");
  a_update_retry: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (state_ff == ST_BOOT && upd_ena_ff && !RESTART_I) |=> state_ff == ST_UPDATE)
    else $error("Pending update not run after restart.");
  a_expert_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (expert_eff_ff && !RESTART_I) |=> expert_eff_ff)
    else $error("Expert mode left without restart.");
  a_fault_slot: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (PERIPH_FAULT_I != '0) |=> ((SLOT_VALID_O & $past(PERIPH_FAULT_I)) == '0))
    else $error("Faulty terminal data marked valid.");
endmodule

// File: ssmc_pkg.sv
package ssmc_pkg;
  // Variable identifiers of the startup switches.
  localparam logic [15:0] VAR_LEARN_MODE = 16'h2240;
  localparam logic [15:0] VAR_EXPERT_MODE = 16'h2275;
  // Firmware commands used in expert mode.
  localparam logic [15:0] CMD_BUILD_CONFIG = 16'h0710;
  localparam logic [15:0] CMD_START_XFER = 16'h0701;
  // Answer code for a refused process data access.
  localparam logic [15:0] ERR_LEARN_ACTIVE = 16'h00a9;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_BAD_SLOT = 16'h00ff;
  localparam int MAX_SLOTS = 63;
  localparam int SLOT_W = 6;

  // Register byte addresses.
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_COUNT = 8'h08;
  localparam logic [7:0] ADR_DIAG_STAT = 8'h0c;
  localparam logic [7:0] ADR_DIAG_PARAM = 8'h10;
  localparam logic [7:0] ADR_CMD = 8'h14;
  localparam logic [7:0] ADR_SLOT_SEL = 8'h18;
  localparam logic [7:0] ADR_SLOT_INFO = 8'h1c;
  localparam logic [7:0] ADR_PD_REQ = 8'h20;

  // Control register fields.
  localparam int CTRL_LEARN = 0;
  localparam int CTRL_EXPERT = 1;
  localparam int CTRL_UPD_ENA = 2;
  localparam int CTRL_AUTO_ADDR = 3;

  // Reset values: learn mode on, expert off, update off, auto address on.
  localparam logic CTRL_LEARN_RST = 1'b1;
  localparam logic CTRL_EXPERT_RST = 1'b0;
  localparam logic CTRL_UPD_RST = 1'b0;
  localparam logic CTRL_AUTO_RST = 1'b1;

  // Terminal classes.
  typedef enum logic [2:0] {
    TT_DIN = 3'h0, TT_DOUT = 3'h1, TT_DIO = 3'h2, TT_AIN = 3'h3,
    TT_AOUT = 3'h4, TT_AIO = 3'h5, TT_PARAM = 3'h6
  } ssmc_ttype_t;

  // Startup sequence, Gray coded in declaration order.
  typedef enum logic [2:0] {
    ST_BOOT = 3'b000, ST_UPDATE = 3'b001, ST_SCAN = 3'b011, ST_CHECK = 3'b010,
    ST_RUN = 3'b110, ST_MISMATCH = 3'b111, ST_EXP_WAIT = 3'b101, ST_EXP_CFG = 3'b100
  } ssmc_state_t;
endpackage

// File: ssmc_chain_model.sv
`timescale 1ns/1ps
// Terminal chain: on go_i it reports positions 1..num_i, then a done pulse.
module ssmc_chain_model (
  // Clock and bench control.
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [5:0] num_i,
  input wire logic [2:0] kind_i,
  // Scan report towards the block.
  output logic valid_o,
  output logic [5:0] slot_o,
  output logic [2:0] type_o,
  output logic [4:0] bits_o,
  output logic [3:0] words_o,
  output logic done_o
);
  logic [5:0] pos_ff = 6'h00;
  logic last_ff = 1'b0;
  logic [2:0] t;
  assign t = 3'((4'(kind_i) + 4'(pos_ff[2:0])) % 4'h7);
  initial begin
    valid_o = 1'b0;
    done_o = 1'b0;
    {slot_o, type_o, bits_o, words_o} = '0;
  end
  always @(posedge clk_i) begin
    valid_o <= (pos_ff != 6'h00);
    last_ff <= (pos_ff != 6'h00) && (pos_ff == num_i);
    done_o <= last_ff;
    if (go_i) begin
      pos_ff <= 6'h01;
    end else if (pos_ff == num_i) begin
      pos_ff <= 6'h00;
    end else if (pos_ff != 6'h00) begin
      pos_ff <= pos_ff + 6'h01;
    end
    if (pos_ff != 6'h00) begin
      slot_o <= pos_ff;
      type_o <= t;
      bits_o <= (t < 3'h3) ? 5'h08 : 5'h00;
      words_o <= (t < 3'h3) ? 4'h1 : 4'h2;
    end else begin
      // Released lines flip each cycle so stale data is never read as a report.
      {slot_o, type_o, bits_o, words_o} <= ~{slot_o, type_o, bits_o, words_o};
    end
  end
endmodule

// File: station_startup_mode_control_test.sv
`timescale 1ns/1ps
module station_startup_mode_control_test;
  import ssmc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0, rd = 1'b0, restart = 1'b0, upd_done = 1'b0, upd_fail = 1'b0;
  logic flash_busy = 1'b0, reply_valid = 1'b0, bus_err = 1'b0, go = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, reply_server = 32'h0, rdata, upd_server, rv;
  logic [15:0] reply_file = 16'h0, diag_stat = 16'h0, diag_cause = 16'h0, upd_file;
  logic [MAX_SLOTS-1:0] fault = '0, slot_valid;
  logic [5:0] num = 6'h04, s_slot;
  logic [2:0] kind = 3'h0, s_type;
  logic [4:0] s_bits;
  logic [3:0] s_words;
  logic s_valid, s_done, start_upd, mgmt, learn_ind, mism_ind, diag_flash;
  logic out_wen, out_rst, bus_run, pd_valid;
  int err_count = 0;
  int samples_checked = 0;

  initial begin
    forever #10 clk = ~clk;
  end

  ssmc_chain_model chain (.clk_i(clk), .go_i(go), .num_i(num), .kind_i(kind),
    .valid_o(s_valid), .slot_o(s_slot), .type_o(s_type), .bits_o(s_bits),
    .words_o(s_words), .done_o(s_done));

  ssmc_top DUT (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RESTART_I(restart),
    .UPD_DONE_I(upd_done), .UPD_FAIL_I(upd_fail), .FLASH_BUSY_I(flash_busy),
    .REPLY_VALID_I(reply_valid), .REPLY_SERVER_I(reply_server),
    .REPLY_FILE_I(reply_file), .SCAN_VALID_I(s_valid), .SCAN_SLOT_I(s_slot),
    .SCAN_TYPE_I(s_type), .SCAN_BITS_I(s_bits), .SCAN_WORDS_I(s_words),
    .SCAN_DONE_I(s_done), .BUS_ERR_I(bus_err), .DIAG_STAT_I(diag_stat),
    .DIAG_CAUSE_I(diag_cause), .PERIPH_FAULT_I(fault), .START_UPDATE_O(start_upd),
    .MGMT_AVAIL_O(mgmt), .UPD_SERVER_O(upd_server), .UPD_FILE_O(upd_file),
    .LEARN_MODE_INDICATOR_O(learn_ind), .CONFIG_MISMATCH_INDICATOR_O(mism_ind),
    .DIAG_FLASH_O(diag_flash), .OUT_WRITE_EN_O(out_wen), .OUTPUTS_RESET_O(out_rst),
    .BUS_RUN_O(bus_run), .PD_VALID_O(pd_valid), .SLOT_VALID_O(slot_valid));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
  // The task returns on a rising edge so that the next stimulus lands there.
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e);
    @(posedge clk);
  endtask

  task automatic reboot();
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    cyc(4);
  endtask

  task automatic scan(input logic [2:0] k, input logic [5:0] n);
    kind <= k;
    num <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    cyc(int'(n) + 10);
  endtask

  task automatic t_defaults();
    rdc(ADR_CTRL, 32'hffffffff, 32'h9);
    chk(32'(learn_ind), 32'h1);
    chk(32'(out_rst), 32'h1);
    rdc(8'hfc, 32'hffffffff, 32'h0);
  endtask

  task automatic t_learn();
    scan(3'h0, 6'h04);
    chk(32'(bus_run), 32'h1);
    chk(32'(out_wen), 32'h0);
    rdc(ADR_COUNT, 32'hffffffff, 32'h4);
    // Position 1 reports an output byte, position 3 a two-word analog input.
    wr_reg(ADR_SLOT_SEL, 32'h1);
    rdc(ADR_SLOT_INFO, 32'hffffffff, 32'h00014001);
    wr_reg(ADR_SLOT_SEL, 32'h3);
    rdc(ADR_SLOT_INFO, 32'hffffffff, 32'h00031022);
    wr_reg(ADR_SLOT_SEL, 32'h5);
    rdc(ADR_SLOT_INFO, 32'hffffffff, {16'h0, ERR_BAD_SLOT});
    wr_reg(ADR_PD_REQ, 32'h1);
    rdc(ADR_PD_REQ, 32'hffffffff, {16'h0, ERR_LEARN_ACTIVE});
    fault <= 63'h2;
    cyc(4);
    chk(32'(slot_valid[1:0]), 32'h1);
    fault <= '0;
    wr_reg(ADR_CTRL, 32'h8);
    cyc(4);
    chk(32'(out_wen), 32'h1);
    chk(32'(out_rst), 32'h0);
    chk(32'(learn_ind), 32'h0);
    wr_reg(ADR_PD_REQ, 32'h1);
    rdc(ADR_PD_REQ, 32'hffffffff, 32'h0);
  endtask

  task automatic t_match();
    reboot();
    scan(3'h0, 6'h04);
    chk({30'h0, bus_run, mism_ind}, 32'h2);
    chk(32'(pd_valid), 32'h1);
    diag_cause <= 16'h1234;
    diag_stat <= 16'h0001;
    bus_err <= 1'b1;
    cyc(4);
    rdc(ADR_COUNT, 32'hffffffff, 32'h4);
    rdc(ADR_DIAG_PARAM, 32'hffff, 32'h1234);
    chk(32'(pd_valid), 32'h0);
    // The blink is still in its dark half this early in the run.
    chk(32'(diag_flash), 32'h0);
    bus_err <= 1'b0;
    diag_stat <= 16'h0;
  endtask

  task automatic t_mismatch();
    reboot();
    scan(3'h1, 6'h04);
    chk({30'h0, bus_run, mism_ind}, 32'h1);
    chk(32'(pd_valid), 32'h0);
    reboot();
    scan(3'h0, 6'h05);
    chk({30'h0, bus_run, mism_ind}, 32'h1);
    wr_reg(ADR_CTRL, 32'h9);
    reboot();
    scan(3'h1, 6'h04);
    wr_reg(ADR_CTRL, 32'h8);
    reboot();
    scan(3'h1, 6'h04);
    chk({30'h0, bus_run, mism_ind}, 32'h2);
  endtask

  task automatic t_expert();
    wr_reg(ADR_CTRL, 32'hb);
    reboot();
    scan(3'h0, 6'h04);
    chk({29'h0, bus_run, mism_ind, learn_ind}, 32'h0);
    wr_reg(ADR_CMD, {16'h0, CMD_BUILD_CONFIG});
    scan(3'h0, 6'h04);
    wr_reg(ADR_CMD, {16'h0, CMD_START_XFER});
    cyc(4);
    chk(32'(bus_run), 32'h1);
    wr_reg(ADR_CTRL, 32'h9);
    rdc(ADR_STATUS, 32'h20, 32'h20);
    reboot();
    rdc(ADR_STATUS, 32'h20, 32'h0);
  endtask

  task automatic t_update();
    wr_reg(ADR_CMD, 32'h80001234);
    wr_reg(ADR_CMD, 32'h40000042);
    cyc(2);
    chk(upd_server, 32'h00001234);
    chk(32'(upd_file), 32'h42);
    wr_reg(ADR_CTRL, 32'hd);
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    reply_valid <= 1'b1;
    reply_server <= 32'hc0a80005;
    reply_file <= 16'h00f1;
    @(posedge clk);
    reply_valid <= 1'b0;
    cyc(4);
    chk(upd_server, 32'hc0a80005);
    chk(32'(upd_file), 32'hf1);
    chk(32'(start_upd), 32'h1);
    upd_fail <= 1'b1;
    @(posedge clk);
    upd_fail <= 1'b0;
    reboot();
    chk(32'(start_upd), 32'h1);
    wr_reg(ADR_CTRL, 32'h9);
    reboot();
    chk(32'(start_upd), 32'h0);
    wr_reg(ADR_CTRL, 32'hd);
    reboot();
    flash_busy <= 1'b1;
    reboot();
    flash_busy <= 1'b0;
    wr_reg(ADR_CTRL, 32'h9);
    reboot();
    chk({30'h0, start_upd, mgmt}, 32'h2);
    upd_done <= 1'b1;
    @(posedge clk);
    upd_done <= 1'b0;
    reboot();
    chk({30'h0, start_upd, mgmt}, 32'h1);
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  initial begin
    cyc(5000);
    err_count++;
    summarize();
  end

  initial begin
    cyc(12);
    rst_n <= 1'b1;
    cyc(2);
    t_defaults();
    t_learn();
    t_match();
    t_mismatch();
    t_expert();
    t_update();
    summarize();
  end
endmodule
